//--- rtl/icpg_pkg.sv
// Constants, field layouts and carrier types of the instruction cache parity guard.
// Assumes one core clock and a plain single-cycle register port from software.
// Behaviour
// - line holds tag, 256 data, 10 parity
// - tag has id, id-disable, address bits
// - two tag parity, eight word parity bits
// - tag parity over alternating tag bits
// - even parity computed and stored on fill
// - fetch read checks stored parity
// - debug read never raises parity error
// - multi-hit on fetch is parity-class error
// - speculative and touch lookups ignore errors
// - error with enable set takes machine check
// - oldest uncommitted address saved on check
// - previous machine state saved on check
// - cause register flags cache parity error
// - check raised before corrupt data commits
// - check immediate, in-flight work flushed
// - tag inject inverts stored tag parity
// - word inject stores odd word parity
// - word 0 inject is configuration MSB
// - inject hits every line filled meanwhile
// - force-miss makes touch refill present line
// - force-miss value has only that bit
// - fetch on duplicate lines raises multi-hit
// - force-miss is big-endian bit 15
package icpg_pkg;
  localparam int ICPG_WORDS = 8;
  localparam int ICPG_WORD_W = 32;
  localparam int ICPG_LINE_W = 256;
  localparam int ICPG_EA_W = 27;
  localparam int ICPG_TID_W = 8;
  localparam int ICPG_TAG_W = ICPG_EA_W + 1 + ICPG_TID_W;
  localparam int ICPG_TPAR_W = 2;
  localparam int ICPG_PAR_W = ICPG_TPAR_W + ICPG_WORDS;
  // Register port and offsets
  localparam int ICPG_ADDR_W = 5;
  localparam logic [4:0] ICPG_OFF_CONFIG = 5'h00;
  localparam logic [4:0] ICPG_OFF_STATE = 5'h04;
  localparam logic [4:0] ICPG_OFF_SAVE_ADDR = 5'h08;
  localparam logic [4:0] ICPG_OFF_SAVE_STATE = 5'h0C;
  localparam logic [4:0] ICPG_OFF_CAUSE = 5'h10;
  // Configuration fields, LSB-0 positions (word 0 inject at the MSB)
  localparam int ICPG_WORD_INJ_MSB = 31;
  localparam int ICPG_TAG_INJ_MSB = 23;
  localparam int ICPG_FORCE_MISS_BIT = 16;
  localparam logic [31:0] ICPG_CONFIG_WMASK = 32'hFFC1_0000;
  localparam logic [31:0] ICPG_CONFIG_RESET = 32'h0000_0000;
  // Machine state and cause fields
  localparam int ICPG_MC_ENABLE_BIT = 12;
  localparam logic [31:0] ICPG_STATE_RESET = 32'h0000_0000;
  localparam int ICPG_CAUSE_PARITY_BIT = 30;
  localparam int ICPG_CAUSE_MULTI_HIT_ERROR_BIT = 29;
  localparam logic [31:0] ICPG_CAUSE_WMASK = 32'h6000_0000;

  typedef enum logic [1:0] {ICPG_LK_FETCH, ICPG_LK_SPEC, ICPG_LK_TOUCH} icpg_lkind_t;

  typedef struct packed {
    logic valid;
    icpg_lkind_t kind;
    logic [ICPG_EA_W-1:0] ea;
    logic [2:0] word;
    logic [ICPG_TID_W-1:0] process_id;
  } icpg_lookup_t;

  typedef struct packed {
    logic valid;
    logic [ICPG_EA_W-1:0] ea;
    logic translation_id_disable;
    logic [ICPG_TID_W-1:0] translation_id;
    logic [ICPG_LINE_W-1:0] data;
  } icpg_fill_t;
endpackage : icpg_pkg

//--- rtl/icpg_guard.sv
// Instruction cache array with parity protection, multi-hit detection and
// machine check capture, plus the inject and force-miss test controls.
// Assumes fetch unit, fill path and register port all run on clk.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module icpg_guard import icpg_pkg::*; #(
  parameter int WAYS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [ICPG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Context synchronisation pulse from the core
  input wire logic ctx_sync,
  // Lookups and fetch answer
  input wire icpg_lookup_t lookup,
  output logic fetch_valid,
  output logic [ICPG_WORD_W-1:0] fetch_data,
  // Line fill request and returning fill
  output logic fill_req,
  output logic [ICPG_EA_W-1:0] fill_req_ea,
  input wire icpg_fill_t fill,
  // Debug read of array contents
  input wire logic dbg_rd,
  input wire logic [$clog2(WAYS)-1:0] dbg_way,
  input wire logic [2:0] dbg_word,
  output logic dbg_valid,
  output logic [ICPG_TAG_W-1:0] dbg_tag,
  output logic [ICPG_WORD_W-1:0] dbg_data,
  output logic [ICPG_PAR_W-1:0] dbg_parity,
  // Machine check
  input wire logic [31:0] oldest_uncommitted_addr,
  output logic mcheck_take,
  output logic pipe_flush
);
  localparam int WAY_W = $clog2(WAYS);

  // Parity over every other tag bit, starting at bit sel
  function automatic logic tag_par(input logic [ICPG_TAG_W-1:0] t, input int sel);
    logic p;
    p = 1'b0;
    for (int i = sel; i < ICPG_TAG_W; i += 2) begin
      p = p ^ t[i];
    end
    return p;
  endfunction : tag_par

  // Array storage
  logic [ICPG_TAG_W-1:0] tag_q [WAYS];
  logic [ICPG_LINE_W-1:0] data_q [WAYS];
  logic [ICPG_PAR_W-1:0] par_q [WAYS];
  logic [WAYS-1:0] vld_q;
  logic [WAY_W-1:0] victim_q;

  // Software state
  logic [31:0] config_q;
  logic [31:0] config_ctx_q;
  logic [31:0] state_q;
  logic [31:0] save_addr_q;
  logic [31:0] save_state_q;
  logic [31:0] cause_q;
  logic [31:0] rdata_q;

  // Output flops
  logic fetch_valid_q;
  logic [ICPG_WORD_W-1:0] fetch_data_q;
  logic fill_req_q;
  logic [ICPG_EA_W-1:0] fill_req_ea_q;
  logic dbg_valid_q;
  logic [ICPG_TAG_W-1:0] dbg_tag_q;
  logic [ICPG_WORD_W-1:0] dbg_data_q;
  logic [ICPG_PAR_W-1:0] dbg_parity_q;
  logic mcheck_take_q;
  logic pipe_flush_q;

  // Active controls as seen by the cache after synchronisation
  logic [ICPG_WORDS-1:0] word_inj;
  logic [ICPG_TPAR_W-1:0] tag_inj;
  logic force_miss;
  logic [ICPG_WORDS-1:0] word_inj_rev;
  logic [ICPG_TPAR_W-1:0] tag_inj_rev;

  assign word_inj_rev = config_ctx_q[ICPG_WORD_INJ_MSB -: ICPG_WORDS];
  assign tag_inj_rev = config_ctx_q[ICPG_TAG_INJ_MSB -: ICPG_TPAR_W];
  assign force_miss = config_ctx_q[ICPG_FORCE_MISS_BIT];

  // Big-endian bit k of the field controls word or tag parity bit k
  always_comb begin
    for (int k = 0; k < ICPG_WORDS; k++) begin
      word_inj[k] = word_inj_rev[ICPG_WORDS-1-k];
    end
    for (int k = 0; k < ICPG_TPAR_W; k++) begin
      tag_inj[k] = tag_inj_rev[ICPG_TPAR_W-1-k];
    end
  end

  // Tag match and per-line parity check, one copy per way
  logic [WAYS-1:0] hit_vec;
  logic [WAYS-1:0] bad_vec;
  genvar gw;
  generate
    for (gw = 0; gw < WAYS; gw++) begin : g_way
      logic [ICPG_EA_W-1:0] t_ea;
      logic t_dis;
      logic [ICPG_TID_W-1:0] t_id;
      logic [ICPG_PAR_W-1:0] recomputed;
      assign {t_ea, t_dis, t_id} = tag_q[gw];
      assign hit_vec[gw] = vld_q[gw] && (t_ea == lookup.ea)
                           && (t_dis || (t_id == lookup.process_id));
      // Recompute even parity and compare with what was stored
      always_comb begin
        for (int s = 0; s < ICPG_TPAR_W; s++) begin
          recomputed[s] = tag_par(tag_q[gw], s);
        end
        for (int w = 0; w < ICPG_WORDS; w++) begin
          recomputed[ICPG_TPAR_W + w] = ^data_q[gw][w*ICPG_WORD_W +: ICPG_WORD_W];
        end
      end
      assign bad_vec[gw] = |(recomputed ^ par_q[gw]);
    end
  endgenerate

  // Hit selection, multi-hit detection
  logic any_hit;
  logic multi_hit_error;
  logic line_bad;
  logic [WAY_W-1:0] hit_way;
  always_comb begin
    int cnt;
    cnt = 0;
    hit_way = '0;
    line_bad = 1'b0;
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (hit_vec[w]) begin
        cnt = cnt + 1;
        hit_way = WAY_W'(w);
      end
    end
    for (int w = 0; w < WAYS; w++) begin
      if (hit_vec[w] && bad_vec[w]) begin
        line_bad = 1'b1;
      end
    end
    any_hit = (cnt != 0);
    multi_hit_error = (cnt > 1);
  end

  // Classification of the current lookup
  logic is_fetch;
  logic fetch_err;
  logic take_check;
  logic want_fill;
  assign is_fetch = lookup.valid && (lookup.kind == ICPG_LK_FETCH);
  // Only real fetches check; speculative and touch lookups see a plain hit
  assign fetch_err = is_fetch && any_hit && (line_bad || multi_hit_error);
  assign take_check = fetch_err && state_q[ICPG_MC_ENABLE_BIT];
  assign want_fill = lookup.valid && (!any_hit
                     || (lookup.kind == ICPG_LK_TOUCH && force_miss));

  // Parity to store for an arriving fill
  logic [ICPG_TAG_W-1:0] fill_tag;
  logic [ICPG_PAR_W-1:0] fill_par;
  assign fill_tag = {fill.ea, fill.translation_id_disable, fill.translation_id};
  always_comb begin
    for (int s = 0; s < ICPG_TPAR_W; s++) begin
      fill_par[s] = tag_par(fill_tag, s) ^ tag_inj[s];
    end
    for (int w = 0; w < ICPG_WORDS; w++) begin
      fill_par[ICPG_TPAR_W + w] = ^fill.data[w*ICPG_WORD_W +: ICPG_WORD_W]
                                  ^ word_inj[w];
    end
  end

  // Line fill into the victim way; every fill sees the inject bits
  always_ff @(posedge clk) begin
    if (reset) begin
      vld_q <= '0;
      victim_q <= '0;
    end else if (fill.valid) begin
      tag_q[victim_q] <= fill_tag;
      data_q[victim_q] <= fill.data;
      par_q[victim_q] <= fill_par;
      vld_q[victim_q] <= 1'b1;
      victim_q <= victim_q + WAY_W'(1);
    end
  end

  // Configuration register and its synchronised copy
  always_ff @(posedge clk) begin
    if (reset) begin
      config_q <= ICPG_CONFIG_RESET;
      config_ctx_q <= ICPG_CONFIG_RESET;
    end else begin
      if (reg_wr && reg_addr == ICPG_OFF_CONFIG) begin
        config_q <= reg_wdata & ICPG_CONFIG_WMASK;
      end
      if (ctx_sync) begin
        config_ctx_q <= config_q;
      end
    end
  end

  // Machine state and save registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ICPG_STATE_RESET;
      save_addr_q <= '0;
      save_state_q <= '0;
    end else if (take_check) begin
      save_addr_q <= oldest_uncommitted_addr;
      save_state_q <= state_q;
      state_q[ICPG_MC_ENABLE_BIT] <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ICPG_OFF_STATE) begin
        state_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == ICPG_OFF_SAVE_ADDR) begin
        save_addr_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == ICPG_OFF_SAVE_STATE) begin
        save_state_q <= reg_wdata;
      end
    end
  end

  // Cause register: write one to clear, a new event wins
  always_ff @(posedge clk) begin
    if (reset) begin
      cause_q <= '0;
    end else begin
      if (reg_wr && reg_addr == ICPG_OFF_CAUSE) begin
        cause_q <= cause_q & ~(reg_wdata & ICPG_CAUSE_WMASK);
      end
      if (take_check) begin
        cause_q[ICPG_CAUSE_PARITY_BIT] <= 1'b1;
        // Only a real multi-hit sets this bit, so a clear in the same cycle still lands
        if (multi_hit_error) begin
          cause_q[ICPG_CAUSE_MULTI_HIT_ERROR_BIT] <= 1'b1;
        end
      end
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ICPG_OFF_CONFIG: rdata_q <= config_q;
        ICPG_OFF_STATE: rdata_q <= state_q;
        ICPG_OFF_SAVE_ADDR: rdata_q <= save_addr_q;
        ICPG_OFF_SAVE_STATE: rdata_q <= save_state_q;
        ICPG_OFF_CAUSE: rdata_q <= cause_q;
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // Fetch answer: data withheld when a check is taken
  always_ff @(posedge clk) begin
    if (reset) begin
      fetch_valid_q <= 1'b0;
      fetch_data_q <= '0;
    end else begin
      fetch_valid_q <= is_fetch && any_hit && !take_check;
      fetch_data_q <= data_q[hit_way][lookup.word*ICPG_WORD_W +: ICPG_WORD_W];
    end
  end

  // Machine check and flush pulses, registered and raised one cycle after the detecting cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      mcheck_take_q <= 1'b0;
      pipe_flush_q <= 1'b0;
    end else begin
      mcheck_take_q <= take_check;
      pipe_flush_q <= take_check;
    end
  end

  // Fill requests for misses and forced touch misses
  always_ff @(posedge clk) begin
    if (reset) begin
      fill_req_q <= 1'b0;
      fill_req_ea_q <= '0;
    end else begin
      fill_req_q <= want_fill;
      if (want_fill) begin
        fill_req_ea_q <= lookup.ea;
      end
    end
  end

  // Debug read returns raw contents and never flags an error
  always_ff @(posedge clk) begin
    if (reset) begin
      dbg_valid_q <= 1'b0;
      dbg_tag_q <= '0;
      dbg_data_q <= '0;
      dbg_parity_q <= '0;
    end else begin
      dbg_valid_q <= dbg_rd;
      if (dbg_rd) begin
        dbg_tag_q <= tag_q[dbg_way];
        dbg_data_q <= data_q[dbg_way][dbg_word*ICPG_WORD_W +: ICPG_WORD_W];
        dbg_parity_q <= par_q[dbg_way];
      end
    end
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_q;
  assign fetch_valid = fetch_valid_q;
  assign fetch_data = fetch_data_q;
  assign fill_req = fill_req_q;
  assign fill_req_ea = fill_req_ea_q;
  assign dbg_valid = dbg_valid_q;
  assign dbg_tag = dbg_tag_q;
  assign dbg_data = dbg_data_q;
  assign dbg_parity = dbg_parity_q;
  assign mcheck_take = mcheck_take_q;
  assign pipe_flush = pipe_flush_q;
endmodule : icpg_guard

//--- sim/icpg_guard_chk.sv
// Port-level checks of fetch, fill, debug and machine check timing.
// Assumes one clock and the synchronous active-high reset of the guard.
`timescale 1ns/100ps
module icpg_guard_chk import icpg_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Requests
  input wire icpg_lookup_t lookup,
  input wire logic dbg_rd,
  // Answers
  input wire logic fetch_valid,
  input wire logic fill_req,
  input wire logic dbg_valid,
  input wire logic mcheck_take,
  input wire logic pipe_flush
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic is_fetch;
  // Real instruction fetch in this cycle
  assign is_fetch = lookup.valid && lookup.kind == ICPG_LK_FETCH;
  // Checks
  chk_take_cause: assert property (mcheck_take |-> $past(is_fetch))
    else $error("machine check without a fetch");
  chk_spec_quiet: assert property (lookup.valid && !is_fetch |=> !mcheck_take)
    else $error("machine check on a speculative or touch lookup");
  chk_dbg_quiet: assert property (dbg_rd && !lookup.valid |=> !mcheck_take)
    else $error("machine check on a debug read");
  chk_dbg_answer: assert property (dbg_rd |=> dbg_valid)
    else $error("debug read not answered");
  chk_flush_pair: assert property (mcheck_take == pipe_flush)
    else $error("flush and machine check apart");
  chk_no_commit: assert property (mcheck_take |-> !fetch_valid)
    else $error("data delivered with machine check");
  chk_one_check: assert property (mcheck_take |=> !mcheck_take)
    else $error("second check while enable cleared");
  chk_fetch_src: assert property (fetch_valid |-> $past(is_fetch))
    else $error("fetch answer without a fetch");
  chk_fill_src: assert property (fill_req |-> $past(lookup.valid))
    else $error("fill request without a lookup");
  // Main scenarios
  cover property (mcheck_take);
  cover property (fill_req);
  cover property (dbg_valid);
endmodule : icpg_guard_chk

bind icpg_guard icpg_guard_chk u_chk (.clk, .reset, .lookup, .dbg_rd, .fetch_valid,
  .fill_req, .dbg_valid, .mcheck_take, .pipe_flush);

//--- sim/icpg_fetch_model.sv
// Memory side of the fetch unit: answers each fill request with a line.
// Assumes the guard's clk; slow adds a stall before the fill.
`timescale 1ns/100ps
module icpg_fetch_model import icpg_pkg::*; #(
  parameter logic [7:0] TRANS_ID = 8'h05
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Stall select
  input wire logic slow,
  // Fill path
  input wire logic fill_req,
  input wire logic [ICPG_EA_W-1:0] fill_req_ea,
  output icpg_fill_t fill
);
  logic [2:0] wait_q;
  logic [ICPG_EA_W-1:0] ea_q;
  logic [ICPG_LINE_W-1:0] line;
  // Word contents tell address and place
  function automatic logic [31:0] wd(input logic [26:0] ea, input logic [2:0] w);
    return {ea[23:0], 5'h00, w};
  endfunction : wd
  // Count from request to fill cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_q <= 3'h0;
      ea_q <= '0;
    end else if (fill_req) begin
      wait_q <= slow ? 3'h4 : 3'h1;
      ea_q <= fill_req_ea;
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end
  end
  // Line assembly
  always_comb begin
    for (int w = 0; w < 8; w++) line[32*w +: 32] = wd(ea_q, w[2:0]);
  end
  // Off the fill cycle the data lines show the inverse
  assign fill = '{valid: wait_q == 3'h1, ea: ea_q, translation_id_disable: 1'h0,
    translation_id: TRANS_ID, data: (wait_q == 3'h1) ? line : ~line};
endmodule : icpg_fetch_model

//--- sim/icpg_guard_tb_top.sv
// Bench for the parity guard: registers, fills, fetches, debug reads.
// Assumes the fetch model answers every fill request.
`timescale 1ns/100ps
module icpg_guard_tb_top import icpg_pkg::*; ;
  localparam logic [31:0] EN = 32'h1 << ICPG_MC_ENABLE_BIT;
  localparam logic [26:0] A = 27'h0000100;
  localparam logic [26:0] B = 27'h0000200;
  localparam logic [26:0] C = 27'h0000300;
  localparam logic [26:0] D = 27'h0000400;
  localparam logic [35:0] TAG_D = {D, 1'h0, 8'h05};
  // Process id carried by each lookup
  logic [7:0] proc_id = 8'h05;
  // Expected word contents, same scheme as the fetch model
  function automatic logic [31:0] line_word(input logic [26:0] ea, input logic [2:0] w);
    return {ea[23:0], 5'h00, w};
  endfunction : line_word
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic ctx_sync = 1'h0;
  logic dbg_rd = 1'h0;
  logic slow = 1'h0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] oldest_uncommitted_addr = 32'h0;
  logic [1:0] dbg_way = 2'h0;
  logic [2:0] dbg_word = 3'h0;
  icpg_lookup_t lookup = '0;
  logic [31:0] reg_rdata, fetch_data, dbg_data;
  logic fetch_valid, fill_req, dbg_valid, mcheck_take, pipe_flush;
  logic [26:0] fill_req_ea;
  logic [35:0] dbg_tag;
  logic [9:0] dbg_parity;
  icpg_fill_t fill;
  int fails = 0;
  int check_count = 0;
  int n;
  // Core clock
  always #25 clk = ~clk;
  // Guard and its fetch side
  icpg_guard #(.WAYS(4)) uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ctx_sync, .lookup, .fetch_valid, .fetch_data, .fill_req, .fill_req_ea,
    .fill, .dbg_rd, .dbg_way, .dbg_word, .dbg_valid, .dbg_tag, .dbg_data, .dbg_parity,
    .oldest_uncommitted_addr, .mcheck_take, .pipe_flush);
  icpg_fetch_model mdl (.clk, .reset, .slow, .fill_req, .fill_req_ea, .fill);

  task automatic wrap_up();
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk(nm, reg_rdata, e);
  endtask : rd

  task automatic sy();
    @(posedge clk);
    ctx_sync <= 1'h1;
    @(posedge clk);
    ctx_sync <= 1'h0;
  endtask : sy

  task automatic look(input icpg_lkind_t k, input logic [26:0] ea, input logic [2:0] w);
    @(posedge clk);
    lookup <= '{1'h1, k, ea, w, proc_id};
    @(posedge clk);
    lookup.valid <= 1'h0;
    #1;
  endtask : look

  task automatic dbg(input logic [1:0] way);
    @(posedge clk);
    dbg_way <= way;
    dbg_rd <= 1'h1;
    @(posedge clk);
    dbg_rd <= 1'h0;
    #1;
  endtask : dbg

  task automatic wfill();
    for (n = 0; n < 20 && fill.valid !== 1'h1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 20) begin
      fails++;
    end
    @(posedge clk);
  endtask : wfill

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    wr(5'h14, 32'hFFFF_FFFF);
    rd(5'h14, 32'h0, "unmapped");
    wr(ICPG_OFF_CONFIG, 32'hFFFF_FFFF);
    rd(ICPG_OFF_CONFIG, 32'hFFC1_0000, "config");
    wr(ICPG_OFF_CONFIG, 32'h0);
    wr(ICPG_OFF_STATE, EN);
    look(ICPG_LK_FETCH, A, 3'h2);
    chk("fill_req_ea", fill_req_ea, A);
    wfill();
    look(ICPG_LK_FETCH, A, 3'h2);
    chk("fetch_data", fetch_data, line_word(A, 3'h2));
    chk("good parity check", mcheck_take, 1'h0);
    // Word 0 inject over two fills
    wr(ICPG_OFF_CONFIG, 32'h8000_0000);
    sy();
    look(ICPG_LK_TOUCH, B, 3'h0);
    wfill();
    look(ICPG_LK_TOUCH, C, 3'h0);
    wfill();
    wr(ICPG_OFF_CONFIG, 32'h0);
    sy();
    look(ICPG_LK_SPEC, B, 3'h0);
    chk("spec check", mcheck_take, 1'h0);
    dbg(2'h1);
    chk("word0 parity", dbg_parity[2], ~^line_word(B, 3'h0));
    chk("word1 parity", dbg_parity[3], ^line_word(B, 3'h1));
    chk("debug data", dbg_data, line_word(B, 3'h0));
    chk("debug check", mcheck_take, 1'h0);
    // Enable clear: data delivered, no check
    wr(ICPG_OFF_STATE, 32'h0);
    look(ICPG_LK_FETCH, B, 3'h0);
    chk("unarmed fetch", fetch_valid, 1'h1);
    rd(ICPG_OFF_CAUSE, 32'h0, "cause idle");
    // Second injected line takes the check
    wr(ICPG_OFF_STATE, EN);
    oldest_uncommitted_addr <= 32'h0000_1234;
    look(ICPG_LK_FETCH, C, 3'h5);
    chk("mcheck_take", mcheck_take, 1'h1);
    chk("pipe_flush", pipe_flush, 1'h1);
    chk("fetch_valid", fetch_valid, 1'h0);
    rd(ICPG_OFF_SAVE_ADDR, 32'h0000_1234, "save addr");
    rd(ICPG_OFF_SAVE_STATE, EN, "save state");
    rd(ICPG_OFF_STATE, 32'h0, "state");
    rd(ICPG_OFF_CAUSE, 32'h4000_0000, "cause");
    wr(ICPG_OFF_CAUSE, 32'h6000_0000);
    rd(ICPG_OFF_CAUSE, 32'h0, "cause clear");
    // Force miss, first without the context sync
    wr(ICPG_OFF_STATE, EN);
    wr(ICPG_OFF_CONFIG, 32'h0001_0000);
    look(ICPG_LK_TOUCH, A, 3'h0);
    chk("touch unsynced", fill_req, 1'h0);
    sy();
    slow <= 1'h1;
    look(ICPG_LK_TOUCH, A, 3'h0);
    chk("touch forced", fill_req, 1'h1);
    wfill();
    slow <= 1'h0;
    wr(ICPG_OFF_CONFIG, 32'h0);
    sy();
    look(ICPG_LK_FETCH, A, 3'h0);
    chk("multi-hit check", mcheck_take, 1'h1);
    rd(ICPG_OFF_CAUSE, 32'h6000_0000, "multi-hit cause");
    // Tag inject on the next fill, which lands in way 0
    wr(ICPG_OFF_CONFIG, 32'h0080_0000);
    sy();
    look(ICPG_LK_TOUCH, D, 3'h0);
    wfill();
    dbg(2'h0);
    chk("tag", dbg_tag, TAG_D);
    chk("tag parity0", dbg_parity[0], ~^(TAG_D & 36'h5_5555_5555));
    chk("tag parity1", dbg_parity[1], ^(TAG_D & 36'hA_AAAA_AAAA));
    // A foreign process id misses the line just filled
    proc_id <= 8'h06;
    look(ICPG_LK_SPEC, D, 3'h0);
    chk("foreign id miss", fill_req, 1'h1);
    wfill();
    wrap_up();
  end
endmodule : icpg_guard_tb_top
